// ### design/ras_pkg.sv
// Package for the return-address stack: widths, reset values, operation codes.
// Assumes one clock domain shared with the program counter and sequencer.
//
// Notes on behaviour
// - PC increment wraps inside its segment; last location is followed by location zero. A save from the last location stores zero of the next segment.
// - Only indirect jump, indirect call, system call, interrupt, return or table resume change the segment.
// - Stack is an index counter plus slot array; index alone selects slot.
// - Calls and accepted interrupts save the return location into the selected slot.
// - Table reads park the resume location on the stack during the fetch.
// - Slots are 16 bits; indices 0 to 14 real; index 15 reads undefined.
// - Index is a 4-bit counter, directly readable and writable; all-ones write forbidden.
// - Call, push or interrupt: index decrements first, then the new slot is written.
// - Return or pop: slot content delivered first, then index increments.
// - Index fifteen yields undefined content; over fifteen nested levels returns nowhere.
package ras_pkg;

  localparam int RAS_IDX_W = 4;
  localparam int RAS_SLOT_W = 16;
  localparam int RAS_SEG_W = 3;
  localparam int RAS_OFS_W = 13;
  localparam logic [3:0] RAS_IDX_EMPTY = 4'hf;
  localparam logic [12:0] RAS_OFS_ZERO = 13'h0000;
  localparam logic [15:0] RAS_PHANTOM_VALUE = 16'h0000;

  // One-hot stack operation request from the sequencer
  typedef struct packed {
    logic push;
    logic pop;
    logic idx_write;
  } ras_op_t;

  // Program counter: segment above an in-segment offset
  typedef struct packed {
    logic [2:0] seg;
    logic [12:0] ofs;
  } ras_pc_t;

  typedef enum logic [2:0] {
    RAS_ST_FETCH = 3'b001,
    RAS_ST_TABLE = 3'b010,
    RAS_ST_RESUME = 3'b100
  } ras_state_t;

endpackage

// ### design/ras_slots.sv
// Slot array of the return-address stack, fifteen real words.
// Assumes the caller supplies an index and a one-cycle write strobe.
`timescale 1ns/10ps
module ras_slots
  import ras_pkg::*;
#(
  parameter int DEPTH = 15
) (
  input wire logic clk, // Core clock
  input wire logic reset, // Asynchronous reset, high
  input wire logic [RAS_IDX_W-1:0] index, // Selected slot
  input wire logic write, // Store data into selected slot
  input wire logic [RAS_SLOT_W-1:0] wdata, // Value to save
  output logic [RAS_SLOT_W-1:0] rdata // Selected slot content
);

  logic [RAS_SLOT_W-1:0] return_slot [DEPTH];

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gen_slot
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          return_slot[g] <= '0;
        end else if (write && index == RAS_IDX_W'(g)) begin
          return_slot[g] <= wdata;
        end
      end
    end
  endgenerate

  // Index 15 has no storage; a fixed filler stands in for undefined data
  always_comb begin
    if (index < RAS_IDX_W'(DEPTH)) begin
      rdata = return_slot[index];
    end else begin
      rdata = RAS_PHANTOM_VALUE;
    end
  end

endmodule

// ### design/ras_stack.sv
// Return-address stack with its index counter and the program counter step.
// Assumes the sequencer asserts at most one request per cycle.
`timescale 1ns/10ps
module ras_stack
  import ras_pkg::*;
(
  input wire logic clk, // Core clock, 10 MHz
  input wire logic reset, // Any reset source, async high
  input wire logic step, // Advance PC sequentially
  input wire logic call, // Call or system call: save and jump
  input wire logic intr, // Interrupt accepted: save and jump
  input wire logic ret, // Return: restore PC from slot
  input wire logic jump_ind, // Indirect jump to target
  input wire logic [RAS_SLOT_W-1:0] target, // Jump or call destination
  input wire logic table_rd, // Start a table read
  input wire logic table_done, // Table word has been fetched
  input wire ras_op_t op, // Push/pop/index write from software
  input wire logic [RAS_SLOT_W-1:0] push_data, // Value for push
  input wire logic [RAS_IDX_W-1:0] idx_wdata, // Index write value
  output ras_pc_t pc, // Program counter
  output logic [RAS_IDX_W-1:0] stack_index, // Current index
  output logic [RAS_SLOT_W-1:0] pop_data, // Value delivered by pop
  output logic table_busy, // Table read in progress
  output logic idx_write_err // Forbidden all-ones index write
);

  ras_state_t state;
  logic [RAS_SLOT_W-1:0] rdata;
  logic [RAS_SLOT_W-1:0] wdata;
  logic [RAS_IDX_W-1:0] next_index;
  logic write;
  logic save;
  logic restore;
  logic [RAS_OFS_W-1:0] next_ofs;

  assign save = call | intr | op.push | (table_rd & state == RAS_ST_FETCH);
  assign restore = ret | op.pop | (state == RAS_ST_RESUME);
  assign table_busy = (state != RAS_ST_FETCH);

  // ------------------------------------------------------------
  // Index counter
  // ------------------------------------------------------------
  always_comb begin
    next_index = stack_index;
    if (save) begin
      next_index = stack_index - 4'h1;
    end else if (restore) begin
      next_index = stack_index + 4'h1;
    end else if (op.idx_write && idx_wdata != RAS_IDX_EMPTY) begin
      next_index = idx_wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stack_index <= RAS_IDX_EMPTY;
    end else begin
      stack_index <= next_index;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx_write_err <= 1'b0;
    end else begin
      idx_write_err <= op.idx_write && idx_wdata == RAS_IDX_EMPTY;
    end
  end

  // Saved word is written at the decremented index in the same edge
  assign write = save;
  assign wdata = op.push ? push_data : {pc.seg, pc.ofs} + 16'h0001;

  ras_slots #(.DEPTH(15)) u_slots (
    .clk(clk),
    .reset(reset),
    .index(save ? next_index : stack_index),
    .write(write),
    .wdata(wdata),
    .rdata(rdata)
  );

  // ------------------------------------------------------------
  // Table read sequence
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= RAS_ST_FETCH;
    end else begin
      case (state)
        RAS_ST_FETCH: if (table_rd) state <= RAS_ST_TABLE;
        RAS_ST_TABLE: if (table_done) state <= RAS_ST_RESUME;
        RAS_ST_RESUME: state <= RAS_ST_FETCH;
        default: state <= RAS_ST_FETCH;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Program counter and popped data
  // ------------------------------------------------------------
  assign next_ofs = pc.ofs + 13'h0001;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc <= '0;
    end else if (ret || state == RAS_ST_RESUME) begin
      pc <= rdata;
    end else if (call || intr || jump_ind) begin
      pc <= target;
    end else if (step && state == RAS_ST_FETCH) begin
      pc.ofs <= next_ofs;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pop_data <= '0;
    end else if (op.pop) begin
      pop_data <= rdata;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_reset_empty;
    @(posedge clk) $fell(reset) |-> stack_index == RAS_IDX_EMPTY;
  endproperty
  a_reset_empty: assert property (p_reset_empty) else $error("index not empty");

  property p_push_dec;
    @(posedge clk) disable iff (reset)
      (call || intr) |=> stack_index == $past(stack_index) - 4'h1;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("save did not decrement");

  property p_pop_inc;
    @(posedge clk) disable iff (reset)
      (ret && !call && !intr && !op.push && !table_rd && state == RAS_ST_FETCH)
      |=> stack_index == $past(stack_index) + 4'h1;
  endproperty
  a_pop_inc: assert property (p_pop_inc) else $error("return did not increment");

  property p_ret_pc;
    @(posedge clk) disable iff (reset) (ret && state == RAS_ST_FETCH) |=> pc == $past(rdata);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return pc wrong");

  property p_seq_seg;
    @(posedge clk) disable iff (reset)
      (step && !ret && !call && !intr && !jump_ind && state == RAS_ST_FETCH)
      |=> pc.seg == $past(pc.seg) && pc.ofs == $past(pc.ofs) + 13'h0001;
  endproperty
  a_seq_seg: assert property (p_seq_seg) else $error("sequential step changed segment");

  property p_no_ones;
    @(posedge clk) disable iff (reset)
      (op.idx_write && !save && !restore)
      |=> stack_index != RAS_IDX_EMPTY || $past(stack_index) == RAS_IDX_EMPTY;
  endproperty
  a_no_ones: assert property (p_no_ones) else $error("all-ones index written");

  // A save in the next cycle moves the read port, so the array itself is checked
  property p_call_saves;
    @(posedge clk) disable iff (reset)
      (call && !op.push)
      |=> stack_index == RAS_IDX_EMPTY || u_slots.return_slot[stack_index] == $past(wdata);
  endproperty
  a_call_saves: assert property (p_call_saves) else $error("return location not saved");

  property p_table_round;
    @(posedge clk) disable iff (reset)
      (table_rd && state == RAS_ST_FETCH && !call && !intr && !op.push && !ret && !op.pop)
      |=> table_busy && stack_index == $past(stack_index) - 4'h0001;
  endproperty
  a_table_round: assert property (p_table_round) else $error("table read did not park");

  property p_jump_pc;
    @(posedge clk) disable iff (reset)
      (jump_ind && !ret && state != RAS_ST_RESUME)
      |=> pc == $past(target);
  endproperty
  a_jump_pc: assert property (p_jump_pc) else $error("indirect jump missed target");

  // Sequential steps must not move the PC while the table word is fetched
  property p_table_hold;
    @(posedge clk) disable iff (reset)
      (state == RAS_ST_TABLE && !ret && !call && !intr && !jump_ind)
      |=> pc == $past(pc);
  endproperty
  a_table_hold: assert property (p_table_hold) else $error("pc moved during table read");

  property p_resume_pop;
    @(posedge clk) disable iff (reset)
      (state == RAS_ST_RESUME && !save)
      |=> !table_busy && stack_index == $past(stack_index) + 4'h1;
  endproperty
  a_resume_pop: assert property (p_resume_pop) else $error("table read did not resume");

  property p_idle_hold;
    @(posedge clk) disable iff (reset)
      (!save && !restore && !op.idx_write) |=> $stable(stack_index);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("index moved without request");

  property p_err_set;
    @(posedge clk) disable iff (reset)
      (op.idx_write && idx_wdata == RAS_IDX_EMPTY) |=> idx_write_err;
  endproperty
  a_err_set: assert property (p_err_set) else $error("forbidden write not flagged");

  property p_err_quiet;
    @(posedge clk) disable iff (reset)
      !(op.idx_write && idx_wdata == RAS_IDX_EMPTY) |=> !idx_write_err;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error flag without cause");

  // Index fifteen has no slot behind it, so a return there lands on the filler
  property p_phantom_ret;
    @(posedge clk) disable iff (reset)
      (ret && !save && stack_index == RAS_IDX_EMPTY) |=> pc == RAS_PHANTOM_VALUE;
  endproperty
  a_phantom_ret: assert property (p_phantom_ret) else $error("empty return not filler");

  c_call: cover property (@(posedge clk) disable iff (reset) call ##[1:20] ret);
  c_table: cover property (@(posedge clk) disable iff (reset)
    table_rd ##[1:20] (state == RAS_ST_RESUME));
  c_wrap: cover property (@(posedge clk) disable iff (reset) step && pc.ofs == 13'h1fff);
  c_phantom: cover property (@(posedge clk) disable iff (reset)
    ret && stack_index == RAS_IDX_EMPTY);
  c_forbid: cover property (@(posedge clk) disable iff (reset)
    op.idx_write && idx_wdata == RAS_IDX_EMPTY);

endmodule

// ### dv/ras_seq_model.sv
// Sequencer model: answers a table read with the fetched-word strobe.
// Assumes table_busy from the stack; lat sets the fetch delay in cycles.
`timescale 1ns/10ps
module ras_seq_model (
  input wire logic clk, // Core clock
  input wire logic reset, // Async reset, high
  input wire logic busy, // Table read in progress
  input wire logic [3:0] lat, // Fetch delay
  output logic done // Word fetched, one cycle
);
  logic [4:0] cnt;
  // One strobe per read; the count parks above lat so the resume phase sees none
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 5'h00;
      done <= 1'b0;
    end else begin
      done <= busy && (cnt == {1'b0, lat});
      if (!busy) cnt <= 5'h00;
      else if (cnt <= {1'b0, lat}) cnt <= cnt + 5'h01;
    end
  end
endmodule

// ### dv/test_return_address_stack.sv
// Testbench for the return-address stack with a sequencer model.
// Assumes registered outputs settle one cycle after a request edge.
`timescale 1ns/10ps
module test_return_address_stack;
  import ras_pkg::*;
  logic clk = 0, reset = 1, step = 0, call = 0, intr = 0, ret = 0, jump_ind = 0, table_rd = 0;
  logic [15:0] target = 0, push_data = 0, epc = 0;
  logic [3:0] idx_wdata = 0, lat = 0, ix = 4'hf;
  ras_op_t op = '0;
  ras_pc_t pc;
  logic [3:0] stack_index;
  logic [15:0] pop_data, stk [16];
  logic table_busy, idx_write_err, table_done;
  logic [31:0] seed = 32'hb241_4c75;
  int error_cnt = 0, n_tests = 0;
  always #50 clk = ~clk;
  ras_stack DUT (.clk(clk), .reset(reset), .step(step), .call(call), .intr(intr), .ret(ret),
    .jump_ind(jump_ind), .target(target), .table_rd(table_rd), .table_done(table_done),
    .op(op), .push_data(push_data), .idx_wdata(idx_wdata), .pc(pc),
    .stack_index(stack_index), .pop_data(pop_data), .table_busy(table_busy),
    .idx_write_err(idx_write_err));
  ras_seq_model seq (.clk(clk), .reset(reset), .busy(table_busy), .lat(lat), .done(table_done));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Sequential step keeps the segment bits
  function automatic logic [15:0] nxt(input logic [15:0] p);
    return {p[15:13], p[12:0] + 13'h0001};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Every strobe is written once per call, so back-to-back requests never glitch
  task automatic req(input int k, input logic [15:0] v);
    logic [8:0] sel;
    sel = (k < 8) ? (9'h001 << k) : 9'h100;
    target = v;
    push_data = v;
    idx_wdata = v[3:0];
    {op.idx_write, op.pop, op.push, table_rd, jump_ind, ret, intr, call, step} = sel;
    @(posedge clk);
    #1;
  endtask
  // Drops every strobe; only used where the next step waits for an edge
  task automatic idle();
    {op.idx_write, op.pop, op.push, table_rd, jump_ind, ret, intr, call, step} = '0;
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    #1 reset = 0;
    chk("index", 16'h000f, stack_index);
    chk("pc", 16'h0000, pc);
    req(4, 16'h1ffe); req(0, 0); req(0, 0);
    chk("pc", nxt(nxt(16'h1ffe)), pc);
    req(4, 16'h5fff); req(0, 0);
    chk("pc", nxt(16'h5fff), pc);
    epc = 16'h4000;
    for (int i = 0; i < 15; i++) begin
      ix--;
      stk[ix] = epc + 16'h0001;
      epc = 16'(rnd());
      req(1 + i % 2, epc);
      chk("index", {12'h000, ix}, stack_index);
      chk("pc", epc, pc);
    end
    for (int i = 0; i < 16; i++) begin
      epc = (ix == 4'hf) ? RAS_PHANTOM_VALUE : stk[ix];
      req(3, 0);
      ix++;
      chk("pc", epc, pc);
      if (i < 15) chk("index", {12'h000, ix}, stack_index);
    end
    idle();
    @(posedge clk);
    #1 reset = 1;
    @(posedge clk);
    #1 reset = 0;
    chk("index", 16'h000f, stack_index);
    ix = 4'hf;
    epc = 16'h0000;
    for (int j = 0; j < 6; j++) begin
      if (j < 3) begin
        ix--;
        stk[ix] = 16'(rnd());
        req(6, stk[ix]);
      end else begin
        req(7, 0);
        chk("pop", stk[ix], pop_data);
        ix++;
      end
      chk("index", {12'h000, ix}, stack_index);
    end
    req(8, 16'h000f);
    chk("err", 16'h0001, {15'h0000, idx_write_err});
    chk("index", 16'h000f, stack_index);
    req(8, 16'h0005);
    chk("err", 16'h0000, {15'h0000, idx_write_err});
    chk("index", 16'h0005, stack_index);
    foreach (stk[k]) if (k < 2) begin
      lat = k ? 4'h5 : 4'h0;
      req(5, 0);
      idle();
      chk("busy", 16'h0001, {15'h0000, table_busy});
      chk("index", 16'h0004, stack_index);
      for (int w = 0; table_busy !== 1'b0; w++) begin
        if (w > 40) begin
          error_cnt++;
          break;
        end
        @(posedge clk);
        #1;
      end
      epc = epc + 16'h0001;
      chk("pc", epc, pc);
      chk("index", 16'h0005, stack_index);
    end
    wrap_up();
  end
endmodule
